// >>> design/ctr_pkg.sv
// Constants shared by the codec, touch and converter control register bank.
// Assumes a 16-bit register word and a 4-bit register address.
package ctr_pkg;
  // Register word and address types
  typedef logic [15:0] ctr_word_t;
  typedef logic [3:0] ctr_addr_t;
  // Register addresses
  localparam ctr_addr_t ADDR_TEL_A = 4'h5;
  localparam ctr_addr_t ADDR_TEL_B = 4'h6;
  localparam ctr_addr_t ADDR_AUD_A = 4'h7;
  localparam ctr_addr_t ADDR_AUD_B = 4'h8;
  localparam ctr_addr_t ADDR_TSC = 4'h9;
  localparam ctr_addr_t ADDR_ADC_CTL = 4'hA;
  localparam ctr_addr_t ADDR_ADC_DAT = 4'hB;
  localparam ctr_addr_t ADDR_ID = 4'hC;
  // Telecom control A fields
  localparam int TEL_DIV_LSB = 0;
  localparam int TEL_LOOP_BIT = 7;
  localparam logic [6:0] TEL_DIV_MIN = 7'h10;
  localparam logic [6:0] TEL_DIV_MAX = 7'h7F;
  localparam logic [6:0] TEL_DIV_RST = 7'h10;
  // Telecom control B fields
  localparam int TEL_HPF_BIT = 3;
  localparam int TEL_CLIP_BIT = 4;
  localparam int TEL_ATT_BIT = 6;
  localparam int TEL_SIDE_BIT = 11;
  localparam int TEL_MUTE_BIT = 13;
  localparam int TEL_IN_BIT = 14;
  localparam int TEL_OUT_BIT = 15;
  // Audio control A fields
  localparam int AUD_DIV_LSB = 0;
  localparam int AUD_GAIN_LSB = 7;
  localparam logic [6:0] AUD_DIV_MIN = 7'h06;
  localparam logic [6:0] AUD_DIV_MAX = 7'h7F;
  localparam logic [6:0] AUD_DIV_RST = 7'h06;
  // Audio control B fields
  localparam int AUD_ATT_LSB = 0;
  localparam int AUD_CLIP_BIT = 6;
  localparam int AUD_LOOP_BIT = 8;
  localparam int AUD_MUTE_BIT = 13;
  localparam int AUD_IN_BIT = 14;
  localparam int AUD_OUT_BIT = 15;
  // Touch-screen control fields
  localparam int TS_POW_LSB = 0;
  localparam int TS_GND_LSB = 4;
  localparam int TS_MODE_LSB = 8;
  localparam int TS_BIAS_BIT = 11;
  localparam int TS_PX_STATE_BIT = 12;
  localparam int TS_MX_STATE_BIT = 13;
  localparam logic [1:0] TS_MODE_INT = 2'h0;
  localparam logic [1:0] TS_MODE_PRESS = 2'h1;
  // Converter control fields
  localparam int ADC_SYNC_BIT = 0;
  localparam int ADC_VREF_BIT = 1;
  localparam int ADC_INPUT_LSB = 2;
  localparam int ADC_EXTREF_BIT = 5;
  localparam int ADC_START_BIT = 7;
  localparam int ADC_ENA_BIT = 15;
  // Converter result fields
  localparam int ADC_DATA_LSB = 5;
  localparam int ADC_VALID_BIT = 15;
  // Identification fields
  localparam int ID_VER_LSB = 0;
  localparam int ID_PART_LSB = 6;
  localparam int ID_SUPP_LSB = 12;
  // Synchroniser input indices
  localparam int SY_CLIP = 0;
  localparam int SY_PX = 1;
  localparam int SY_MX = 2;
  localparam int SY_RDY = 3;
  localparam int SY_N = 4;
  // Generic reset value for cleared fields
  localparam ctr_word_t WORD_ZERO = 16'h0000;
endpackage : ctr_pkg

// >>> design/ctr_regs.sv
// Control and status register bank for the telecom codec, audio codec,
// touch-screen switch matrix and 10-bit converter.
// Assumes the serial bus framing sits outside and hands over one decoded
// access per pulse; analog events arrive asynchronously and are synchronised.
//
// What this block does
// RQ1 - Telecom divisor bits 6:0, 16..127, resets 16
// RQ2 - Bit 7 enables telecom loopback, resets zero
// RQ3 - Bit 3 enables telecom voice band filter
// RQ4 - Bit 4 reads clip; rising write clears
// RQ5 - Bit 6 applies fixed 6dB telecom attenuation
// RQ6 - Bit 11 activates sidetone suppression, resets zero
// RQ7 - Bits 13/14/15 telecom mute, input, output
// RQ8 - Audio divisor bits 6:0, 6..127, resets 6
// RQ9 - Audio input gain bits 11:7, resets zero
// RQ10 - Audio output attenuation bits 4:0, resets zero
// RQ11 - Bit 6 audio clip detect, bit 8 loopback
// RQ12 - Bits 13/14/15 audio mute, input, output
// RQ13 - Touch bits 0-3 supply, 4-7 ground
// RQ14 - Touch mode 00 interrupt, 01 pressure, 1x position
// RQ15 - Touch bit 11 activates bias circuitry
// RQ16 - Bits 12/13 read inverted plate pin levels
// RQ17 - Converter bit 15 power, bit 0 sync
// RQ18 - Bit 1 internal reference, bit 5 external
// RQ19 - Input select bits 4:2, touch then auxiliary
// RQ20 - Conversion starts only on bit 7 rising
// RQ21 - Result bits 14:5, bit 15 done flag
// RQ22 - Read-only identification: version, part, supplier
// RQ23 - Converter-ready rising edge offered as interrupt source
// RQ24 - Unassigned bits read zero, writes ignored
`timescale 1ns/1ns
`default_nettype none
module ctr_regs #(
  parameter logic [5:0] ID_VERSION = 6'h05, // Arbitrary value
  parameter logic [5:0] ID_PART = 6'h2A, // Arbitrary value
  parameter logic [3:0] ID_SUPPLIER = 4'h9 // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ctr_pkg::ctr_addr_t regAddr,
  input wire logic regWrite,
  input wire ctr_pkg::ctr_word_t regWdata,
  output var ctr_pkg::ctr_word_t regRdata,
  input wire logic telClipIn,
  input wire logic tspxPinIn,
  input wire logic tsmxPinIn,
  input wire logic adcReadyIn,
  input wire logic [9:0] adcResultIn,
  output logic [6:0] telDiv,
  output logic telLoopEna,
  output logic telFilterEna,
  output logic telClipStat,
  output logic telAttEna,
  output logic telSideSupEna,
  output logic telMute,
  output logic telInEna,
  output logic telOutEna,
  output logic [6:0] audDiv,
  output logic [4:0] audGain,
  output logic [4:0] audAtt,
  output logic audClipEna,
  output logic audLoopEna,
  output logic audMute,
  output logic audInEna,
  output logic audOutEna,
  output logic [3:0] tsPlatePow,
  output logic [3:0] tsPlateGnd,
  output logic [1:0] tsMode,
  output logic tsBiasEna,
  output logic adcSyncEna,
  output logic adcVrefCon,
  output logic [2:0] adcInputSel,
  output logic adcExtRefEna,
  output logic adcEna,
  output logic adcStartPulse,
  output logic adcReadyRise
);
  import ctr_pkg::*;

  // Telecom register state
  logic [6:0] telDiv_ff;
  logic telLoop_ff;
  logic telFilter_ff;
  logic telClip_ff;
  logic clipWrLast_ff; // Last value written to the clip clear bit
  logic telAtt_ff;
  logic telSide_ff;
  logic telMute_ff;
  logic telIn_ff;
  logic telOut_ff;
  // Audio register state
  logic [6:0] audDiv_ff;
  logic [4:0] audGain_ff;
  logic [4:0] audAtt_ff;
  logic audClip_ff;
  logic audLoop_ff;
  logic audMute_ff;
  logic audIn_ff;
  logic audOut_ff;
  // Touch-screen register state
  logic [3:0] tsPow_ff;
  logic [3:0] tsGnd_ff;
  logic [1:0] tsMode_ff;
  logic tsBias_ff;
  // Converter register state
  logic adcSync_ff;
  logic adcVref_ff;
  logic [2:0] adcInput_ff;
  logic adcExtRef_ff;
  logic adcStartBit_ff; // Last written start bit, for edge detection
  logic adcEna_ff;
  logic adcStartPulse_ff;
  logic [9:0] adcData_ff;
  logic adcValid_ff;
  logic adcRise_ff;
  logic rdyLast_ff; // Previous filtered converter-ready level
  // Read data register
  ctr_word_t rdata_ff;
  // Synchroniser stages and filtered levels
  logic [SY_N-1:0] syA_ff;
  logic [SY_N-1:0] syB_ff;
  logic [SY_N-1:0] syC_ff;
  logic [SY_N-1:0] syFilt_ff;
  // Raw asynchronous inputs gathered for the synchroniser loop
  wire logic [SY_N-1:0] syRaw = {adcReadyIn, tsmxPinIn, tspxPinIn, telClipIn};
  // Three-stage synchroniser; level accepted once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SY_N; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          syA_ff[gi] <= 1'b0;
          syB_ff[gi] <= 1'b0;
          syC_ff[gi] <= 1'b0;
          syFilt_ff[gi] <= 1'b0;
        end
        else
        begin
          syA_ff[gi] <= syRaw[gi];
          syB_ff[gi] <= syA_ff[gi];
          syC_ff[gi] <= syB_ff[gi];
          if (syB_ff[gi] == syC_ff[gi])
          begin
            syFilt_ff[gi] <= syC_ff[gi];
          end
        end
      end
    end
  endgenerate
  // Address decode of the write strobe
  wire logic wrTelA = regWrite && (regAddr == ADDR_TEL_A);
  wire logic wrTelB = regWrite && (regAddr == ADDR_TEL_B);
  wire logic wrAudA = regWrite && (regAddr == ADDR_AUD_A);
  wire logic wrAudB = regWrite && (regAddr == ADDR_AUD_B);
  wire logic wrTsc = regWrite && (regAddr == ADDR_TSC);
  wire logic wrAdc = regWrite && (regAddr == ADDR_ADC_CTL);
  // Divisor write data and range checks; out-of-range writes keep the old value
  wire logic [6:0] wrTelDiv = regWdata[TEL_DIV_LSB +: 7];
  wire logic [6:0] wrAudDiv = regWdata[AUD_DIV_LSB +: 7];
  wire logic telDivOk = (wrTelDiv >= TEL_DIV_MIN) && (wrTelDiv <= TEL_DIV_MAX); // see RQ1
  wire logic audDivOk = (wrAudDiv >= AUD_DIV_MIN) && (wrAudDiv <= AUD_DIV_MAX); // see RQ8
  // Event terms
  wire logic clipClear = wrTelB && regWdata[TEL_CLIP_BIT] && !clipWrLast_ff; // see RQ4
  wire logic adcStartEdge = wrAdc && regWdata[ADC_START_BIT] && !adcStartBit_ff; // see RQ20
  wire logic rdyRiseNow = syFilt_ff[SY_RDY] && !rdyLast_ff; // see RQ23
  // Telecom control registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      telDiv_ff <= TEL_DIV_RST; // see RQ1
      telLoop_ff <= 1'b0;
      telFilter_ff <= 1'b0;
      clipWrLast_ff <= 1'b0;
      telAtt_ff <= 1'b0;
      telSide_ff <= 1'b0;
      telMute_ff <= 1'b0;
      telIn_ff <= 1'b0;
      telOut_ff <= 1'b0;
    end
    else
    begin
      if (wrTelA && telDivOk)
      begin
        telDiv_ff <= wrTelDiv; // see RQ1
      end
      if (wrTelA)
      begin
        telLoop_ff <= regWdata[TEL_LOOP_BIT]; // see RQ2
      end
      if (wrTelB)
      begin
        telFilter_ff <= regWdata[TEL_HPF_BIT]; // see RQ3
        clipWrLast_ff <= regWdata[TEL_CLIP_BIT]; // see RQ4
        telAtt_ff <= regWdata[TEL_ATT_BIT]; // see RQ5
        telSide_ff <= regWdata[TEL_SIDE_BIT]; // see RQ6
        telMute_ff <= regWdata[TEL_MUTE_BIT]; // see RQ7
        telIn_ff <= regWdata[TEL_IN_BIT]; // see RQ7
        telOut_ff <= regWdata[TEL_OUT_BIT]; // see RQ7
      end
    end
  end

  // Telecom clip status: a clip event in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      telClip_ff <= 1'b0;
    end
    else if (syFilt_ff[SY_CLIP])
    begin
      telClip_ff <= 1'b1; // see RQ4
    end
    else if (clipClear)
    begin
      telClip_ff <= 1'b0; // see RQ4
    end
  end

  // Audio control registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      audDiv_ff <= AUD_DIV_RST; // see RQ8
      audGain_ff <= 5'h00;
      audAtt_ff <= 5'h00;
      audClip_ff <= 1'b0;
      audLoop_ff <= 1'b0;
      audMute_ff <= 1'b0;
      audIn_ff <= 1'b0;
      audOut_ff <= 1'b0;
    end
    else
    begin
      if (wrAudA && audDivOk)
      begin
        audDiv_ff <= wrAudDiv; // see RQ8
      end
      if (wrAudA)
      begin
        audGain_ff <= regWdata[AUD_GAIN_LSB +: 5]; // see RQ9
      end
      if (wrAudB)
      begin
        audAtt_ff <= regWdata[AUD_ATT_LSB +: 5]; // see RQ10
        audClip_ff <= regWdata[AUD_CLIP_BIT]; // see RQ11
        audLoop_ff <= regWdata[AUD_LOOP_BIT]; // see RQ11
        audMute_ff <= regWdata[AUD_MUTE_BIT]; // see RQ12
        audIn_ff <= regWdata[AUD_IN_BIT]; // see RQ12
        audOut_ff <= regWdata[AUD_OUT_BIT]; // see RQ12
      end
    end
  end

  // Touch-screen control register; state bits are read-only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tsPow_ff <= 4'h0;
      tsGnd_ff <= 4'h0;
      tsMode_ff <= TS_MODE_INT;
      tsBias_ff <= 1'b0;
    end
    else if (wrTsc)
    begin
      tsPow_ff <= regWdata[TS_POW_LSB +: 4]; // see RQ13
      tsGnd_ff <= regWdata[TS_GND_LSB +: 4]; // see RQ13
      tsMode_ff <= regWdata[TS_MODE_LSB +: 2]; // see RQ14
      tsBias_ff <= regWdata[TS_BIAS_BIT]; // see RQ15
    end
  end

  // Converter control register and start edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      adcSync_ff <= 1'b0;
      adcVref_ff <= 1'b0;
      adcInput_ff <= 3'h0;
      adcExtRef_ff <= 1'b0;
      adcStartBit_ff <= 1'b0;
      adcEna_ff <= 1'b0;
      adcStartPulse_ff <= 1'b0;
    end
    else
    begin
      adcStartPulse_ff <= adcStartEdge; // see RQ20
      if (wrAdc)
      begin
        adcSync_ff <= regWdata[ADC_SYNC_BIT]; // see RQ17
        adcVref_ff <= regWdata[ADC_VREF_BIT]; // see RQ18
        adcInput_ff <= regWdata[ADC_INPUT_LSB +: 3]; // see RQ19
        adcExtRef_ff <= regWdata[ADC_EXTREF_BIT]; // see RQ18
        adcStartBit_ff <= regWdata[ADC_START_BIT]; // see RQ20
        adcEna_ff <= regWdata[ADC_ENA_BIT]; // see RQ17
      end
    end
  end

  // Converter result capture and done flag; completion wins over a new start
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      adcData_ff <= 10'h000;
      adcValid_ff <= 1'b0;
      adcRise_ff <= 1'b0;
      rdyLast_ff <= 1'b0;
    end
    else
    begin
      rdyLast_ff <= syFilt_ff[SY_RDY];
      adcRise_ff <= rdyRiseNow; // see RQ23
      if (rdyRiseNow)
      begin
        adcData_ff <= adcResultIn; // see RQ21
        adcValid_ff <= 1'b1; // see RQ21
      end
      else if (adcStartEdge)
      begin
        adcValid_ff <= 1'b0; // see RQ21
      end
    end
  end
  // Read-back words; unassigned bits are zero
  wire ctr_word_t rdTelA = {8'h00, telLoop_ff, telDiv_ff}; // see RQ24
  wire ctr_word_t rdTelB = {telOut_ff, telIn_ff, telMute_ff, 1'b0, telSide_ff, 4'h0,
                   telAtt_ff, 1'b0, telClip_ff, telFilter_ff, 3'h0}; // see RQ24
  wire ctr_word_t rdAudA = {4'h0, audGain_ff, audDiv_ff}; // see RQ24
  wire ctr_word_t rdAudB = {audOut_ff, audIn_ff, audMute_ff, 4'h0, audLoop_ff, 1'b0,
                   audClip_ff, 1'b0, audAtt_ff}; // see RQ24
  wire ctr_word_t rdTsc = {2'h0, !syFilt_ff[SY_MX], !syFilt_ff[SY_PX], tsBias_ff, 1'b0,
                  tsMode_ff, tsGnd_ff, tsPow_ff}; // see RQ16
  wire ctr_word_t rdAdc = {adcEna_ff, 7'h00, adcStartBit_ff, 1'b0, adcExtRef_ff, adcInput_ff,
                  adcVref_ff, adcSync_ff}; // see RQ24
  wire ctr_word_t rdAdcDat = {adcValid_ff, adcData_ff, 5'h00}; // see RQ21
  wire ctr_word_t rdId = {ID_SUPPLIER, ID_PART, ID_VERSION}; // see RQ22
  // Read multiplexer; unmapped addresses return zero
  wire ctr_word_t rdSel = (regAddr == ADDR_TEL_A) ? rdTelA :
                 (regAddr == ADDR_TEL_B) ? rdTelB :
                 (regAddr == ADDR_AUD_A) ? rdAudA :
                 (regAddr == ADDR_AUD_B) ? rdAudB :
                 (regAddr == ADDR_TSC) ? rdTsc :
                 (regAddr == ADDR_ADC_CTL) ? rdAdc :
                 (regAddr == ADDR_ADC_DAT) ? rdAdcDat :
                 (regAddr == ADDR_ID) ? rdId : WORD_ZERO;
  // Registered read data, one cycle behind the address
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_ff <= WORD_ZERO;
    end
    else
    begin
      rdata_ff <= rdSel;
    end
  end
  // Outputs straight from flip-flops
  assign regRdata = rdata_ff;
  assign telDiv = telDiv_ff;
  assign telLoopEna = telLoop_ff;
  assign telFilterEna = telFilter_ff;
  assign telClipStat = telClip_ff;
  assign telAttEna = telAtt_ff;
  assign telSideSupEna = telSide_ff;
  assign telMute = telMute_ff;
  assign telInEna = telIn_ff;
  assign telOutEna = telOut_ff;
  assign audDiv = audDiv_ff;
  assign audGain = audGain_ff;
  assign audAtt = audAtt_ff;
  assign audClipEna = audClip_ff;
  assign audLoopEna = audLoop_ff;
  assign audMute = audMute_ff;
  assign audInEna = audIn_ff;
  assign audOutEna = audOut_ff;
  assign tsPlatePow = tsPow_ff;
  assign tsPlateGnd = tsGnd_ff;
  assign tsMode = tsMode_ff;
  assign tsBiasEna = tsBias_ff;
  assign adcSyncEna = adcSync_ff;
  assign adcVrefCon = adcVref_ff;
  assign adcInputSel = adcInput_ff;
  assign adcExtRefEna = adcExtRef_ff;
  assign adcEna = adcEna_ff;
  assign adcStartPulse = adcStartPulse_ff;
  assign adcReadyRise = adcRise_ff;
endmodule : ctr_regs
`default_nettype wire

// >>> tb/ctr_regs_monitor.sv
// Checker for the control register bank: resets, divisors, read-back, start and done events.
// Assumes it is bound to ctr_regs and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module ctr_regs_monitor #(
  parameter logic [5:0] ID_VERSION = 6'h05, // Arbitrary value
  parameter logic [5:0] ID_PART = 6'h2A, // Arbitrary value
  parameter logic [3:0] ID_SUPPLIER = 4'h9 // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ctr_pkg::ctr_addr_t regAddr,
  input wire logic regWrite,
  input wire ctr_pkg::ctr_word_t regWdata,
  input wire ctr_pkg::ctr_word_t regRdata,
  input wire logic telClipIn,
  input wire logic adcReadyIn,
  input wire logic [6:0] telDiv,
  input wire logic telClipStat,
  input wire logic [6:0] audDiv,
  input wire logic adcStartPulse,
  input wire logic adcReadyRise
);
  import ctr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Write decodes
  wire logic wrTelA = regWrite && regAddr == ADDR_TEL_A;
  wire logic wrAudA = regWrite && regAddr == ADDR_AUD_A;
  wire logic wrAudB = regWrite && regAddr == ADDR_AUD_B;
  wire logic wrAdc = regWrite && regAddr == ADDR_ADC_CTL;
  logic lastStart_ff; // Start bit as last written
  wire logic nxt_lastStart = wrAdc ? regWdata[ADC_START_BIT] : lastStart_ff;
  wire logic startReq = wrAdc && regWdata[ADC_START_BIT] && !lastStart_ff;
  // Track the last written start bit
  always_ff @(posedge clk)
    lastStart_ff <= sys_rst ? 1'b0 : nxt_lastStart;
  sequence audBWriteRead;
    wrAudB ##1 (regAddr == ADDR_AUD_B && !regWrite);
  endsequence
  sequence doneThenRead;
    adcReadyRise ##1 (regAddr == ADDR_ADC_DAT && !startReq);
  endsequence
  reset_values_a: assert property (disable iff (1'b0) sys_rst |=>
    telDiv == TEL_DIV_RST && audDiv == AUD_DIV_RST && regRdata == WORD_ZERO && !adcStartPulse)
    else $error("reset values wrong");
  tel_div_a: assert property (wrTelA && regWdata[6:0] >= TEL_DIV_MIN |=>
    telDiv == $past(regWdata[6:0])) else $error("telecom divisor not taken");
  tel_div_keep_a: assert property (wrTelA && regWdata[6:0] < TEL_DIV_MIN |=>
    $stable(telDiv)) else $error("telecom divisor took invalid value");
  aud_div_a: assert property (wrAudA && regWdata[6:0] >= AUD_DIV_MIN |=>
    audDiv == $past(regWdata[6:0])) else $error("audio divisor not taken");
  id_read_a: assert property (regAddr == ADDR_ID |=>
    regRdata == {ID_SUPPLIER, ID_PART, ID_VERSION}) else $error("id word wrong");
  aud_b_mask_a: assert property (audBWriteRead |=>
    regRdata == ($past(regWdata, 2) & 16'hE15F)) else $error("audio B read-back wrong");
  start_edge_a: assert property (startReq |=> adcStartPulse)
    else $error("start edge gave no pulse");
  start_only_a: assert property (!startReq |=> !adcStartPulse)
    else $error("start pulse without edge");
  ready_rise_a: assert property ($rose(adcReadyIn) |-> ##[2:6] adcReadyRise)
    else $error("ready event missing");
  done_flag_a: assert property (doneThenRead |=> regRdata[ADC_VALID_BIT])
    else $error("done flag not set");
  clip_set_a: assert property ($rose(telClipIn) |-> ##[2:6] telClipStat)
    else $error("clip status not set");
endmodule : ctr_regs_monitor
bind ctr_regs ctr_regs_monitor #(.ID_VERSION(ID_VERSION), .ID_PART(ID_PART),
  .ID_SUPPLIER(ID_SUPPLIER)) i_ctr_regs_monitor (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
  .telClipIn(telClipIn), .adcReadyIn(adcReadyIn), .telDiv(telDiv),
  .telClipStat(telClipStat), .audDiv(audDiv), .adcStartPulse(adcStartPulse),
  .adcReadyRise(adcReadyRise));
`default_nettype wire

// >>> tb/ctr_adc_model.sv
// Behavioural converter: answers each start pulse with a fixed result after a delay.
// Assumes the start pulse is one clock wide and synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module ctr_adc_model #(
  parameter int CONV_CYCLES = 10, // Conversion time in clocks
  parameter logic [9:0] RESULT = 10'h2A5 // Value every conversion returns
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic startPulse,
  output logic readyOut,
  output logic [9:0] resultOut
);
  int count_ff; // Clocks left in the conversion
  // Result is scrambled while no conversion is done, so stale data cannot pass
  always_ff @(posedge clk)
  begin
    if (sys_rst || startPulse)
    begin
      readyOut <= 1'b0;
      resultOut <= ~RESULT;
      count_ff <= sys_rst ? 0 : CONV_CYCLES;
    end
    else if (count_ff == 1)
    begin
      readyOut <= 1'b1;
      resultOut <= RESULT;
      count_ff <= 0;
    end
    else if (count_ff > 1)
      count_ff <= count_ff - 1;
  end
endmodule : ctr_adc_model
`default_nettype wire

// >>> tb/ctr_regs_test.sv
// Self-checking bench for the control register bank.
// Assumes ctr_regs with its default identity values and the converter model.
`timescale 1ns/1ns
`default_nettype none
module ctr_regs_test;
  import ctr_pkg::*;
  logic clk, sys_rst, regWrite, telClipIn, tspxPinIn, tsmxPinIn, adcReadyIn;
  ctr_addr_t regAddr;
  ctr_word_t regWdata, regRdata;
  logic [9:0] adcResultIn;
  logic [6:0] telDiv, audDiv;
  logic [4:0] audGain, audAtt;
  logic [3:0] tsPlatePow, tsPlateGnd;
  logic [2:0] adcInputSel;
  logic [1:0] tsMode;
  logic telLoopEna, telClipStat, telOutEna, audOutEna, adcEna, adcStartPulse, adcReadyRise;
  wire logic [12:0] fieldOut; // Single-bit enables: telecom, audio, converter, bias
  int num_errors = 0;
  int n_tests = 0;
  int nStart = 0; // Start pulses seen
  int cycles = 0; // Watchdog count
  ctr_regs i_ctr_regs (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .telClipIn(telClipIn), .tspxPinIn(tspxPinIn),
    .tsmxPinIn(tsmxPinIn), .adcReadyIn(adcReadyIn), .adcResultIn(adcResultIn),
    .telDiv(telDiv), .telLoopEna(telLoopEna), .telFilterEna(fieldOut[0]),
    .telClipStat(telClipStat), .telAttEna(fieldOut[1]), .telSideSupEna(fieldOut[2]),
    .telMute(fieldOut[3]), .telInEna(fieldOut[4]), .telOutEna(telOutEna),
    .audDiv(audDiv), .audGain(audGain), .audAtt(audAtt), .audClipEna(fieldOut[5]),
    .audLoopEna(fieldOut[6]), .audMute(fieldOut[7]), .audInEna(fieldOut[8]),
    .audOutEna(audOutEna), .tsPlatePow(tsPlatePow), .tsPlateGnd(tsPlateGnd), .tsMode(tsMode),
    .tsBiasEna(fieldOut[12]), .adcSyncEna(fieldOut[9]), .adcVrefCon(fieldOut[10]),
    .adcInputSel(adcInputSel), .adcExtRefEna(fieldOut[11]), .adcEna(adcEna),
    .adcStartPulse(adcStartPulse), .adcReadyRise(adcReadyRise));
  ctr_adc_model i_ctr_adc_model (.clk(clk), .sys_rst(sys_rst), .startPulse(adcStartPulse),
    .readyOut(adcReadyIn), .resultOut(adcResultIn));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Start counter and watchdog
  always @(posedge clk)
  begin
    if (adcStartPulse === 1'b1)
      nStart++;
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic check(input string name, input ctr_word_t exp, input ctr_word_t got);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : check
  task automatic wr(input ctr_addr_t a, input ctr_word_t d);
    @(posedge clk);
    regAddr <= a;
    regWrite <= 1'b1;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input ctr_addr_t a, input ctr_word_t exp, input string name);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    #1 check(name, exp, regRdata);
  endtask : rd
  task automatic t_reset();
    rd(ADDR_TEL_A, 16'h0010, "telA");
    rd(ADDR_TEL_B, WORD_ZERO, "telB");
    rd(ADDR_AUD_A, 16'h0006, "audA");
    rd(ADDR_AUD_B, WORD_ZERO, "audB");
    rd(ADDR_TSC, WORD_ZERO, "tsc");
    rd(ADDR_ADC_CTL, WORD_ZERO, "adcCtl");
    rd(ADDR_ADC_DAT, WORD_ZERO, "adcDat");
    rd(ADDR_ID, {4'h9, 6'h2A, 6'h05}, "id");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fields();
    wr(ADDR_TEL_A, 16'hFF90);
    rd(ADDR_TEL_A, 16'h0090, "telA");
    check("telLoopEna", 16'h1, telLoopEna);
    wr(ADDR_TEL_A, 16'h000F);
    rd(ADDR_TEL_A, 16'h0010, "telA low");
    wr(ADDR_TEL_A, 16'h007F);
    check("telDiv", 16'h7F, telDiv);
    wr(ADDR_AUD_A, 16'hFF85);
    rd(ADDR_AUD_A, 16'h0F86, "audA");
    check("audGain", 16'h1F, audGain);
    wr(ADDR_AUD_A, 16'h007F);
    check("audDiv", 16'h7F, audDiv);
    $display("t_fields done");
  endtask : t_fields
  task automatic t_ctrl();
    wr(ADDR_TEL_B, 16'hFFFF);
    rd(ADDR_TEL_B, 16'hE848, "telB");
    check("telOutEna", 16'h1, telOutEna);
    wr(ADDR_AUD_B, 16'hFFFF);
    rd(ADDR_AUD_B, 16'hE15F, "audB");
    check("audAtt", 16'h1F, audAtt);
    check("audOutEna", 16'h1, audOutEna);
    check("fieldOut", 16'h01FF, {3'h0, fieldOut});
    wr(ADDR_ADC_CTL, 16'hFF7F);
    rd(ADDR_ADC_CTL, 16'h803F, "adcCtl");
    check("adcEna", 16'h1, adcEna);
    check("fieldOut adc", 16'h0FFF, {3'h0, fieldOut});
    for (int s = 0; s < 8; s++)
    begin
      wr(ADDR_ADC_CTL, {11'h0, s[2:0], 2'b00});
      check("adcInputSel", s[2:0], adcInputSel);
    end
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_TSC, {6'h00, m[1:0], 8'hA5});
      rd(ADDR_TSC, {6'h00, m[1:0], 8'hA5}, "tsc");
      check("tsMode", m[1:0], tsMode);
    end
    check("tsPlatePow", 16'h5, tsPlatePow);
    check("tsPlateGnd", 16'hA, tsPlateGnd);
    wr(ADDR_TSC, 16'hFFFF);
    rd(ADDR_TSC, 16'h0BFF, "tsc all");
    check("fieldOut tsc", 16'h11FF, {3'h0, fieldOut});
    $display("t_ctrl done");
  endtask : t_ctrl
  task automatic t_pins();
    @(posedge clk);
    tspxPinIn <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ADDR_TSC, 16'h1BFF, "tspx low");
    @(posedge clk);
    tsmxPinIn <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ADDR_TSC, 16'h3BFF, "tsmx low");
    @(posedge clk);
    tspxPinIn <= 1'b1;
    tsmxPinIn <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ADDR_TSC, 16'h0BFF, "pins high");
    $display("t_pins done");
  endtask : t_pins
  task automatic t_clip();
    @(posedge clk);
    telClipIn <= 1'b1;
    repeat (4) @(posedge clk);
    telClipIn <= 1'b0;
    repeat (8) @(posedge clk);
    rd(ADDR_TEL_B, 16'hE858, "clip set");
    check("telClipStat", 16'h1, telClipStat);
    wr(ADDR_TEL_B, 16'hE848);
    rd(ADDR_TEL_B, 16'hE858, "clip kept");
    wr(ADDR_TEL_B, 16'hE858);
    rd(ADDR_TEL_B, 16'hE848, "clip cleared");
    $display("t_clip done");
  endtask : t_clip
  task automatic wait_done();
    for (int i = 0; i < 40 && adcReadyRise !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    check("adcReadyRise", 16'h1, adcReadyRise);
    rd(ADDR_ADC_DAT, 16'hD4A0, "result");
  endtask : wait_done
  task automatic t_adc();
    int s;
    s = nStart;
    wr(ADDR_ADC_CTL, 16'h0080);
    rd(ADDR_ADC_DAT, WORD_ZERO, "busy");
    check("starts", 16'(s + 1), 16'(nStart));
    wait_done();
    wr(ADDR_ADC_CTL, 16'h0080);
    rd(ADDR_ADC_DAT, 16'hD4A0, "no restart");
    check("starts again", 16'(s + 1), 16'(nStart));
    wr(ADDR_ADC_CTL, WORD_ZERO);
    wr(ADDR_ADC_CTL, 16'h0080);
    wait_done();
    check("second start", 16'(s + 2), 16'(nStart));
    $display("t_adc done");
  endtask : t_adc
  task automatic t_ro();
    wr(ADDR_ADC_DAT, 16'hFFFF);
    wr(ADDR_ID, WORD_ZERO);
    wr(4'h0, 16'hFFFF);
    wr(4'hD, 16'hFFFF);
    rd(ADDR_ADC_DAT, 16'hD4A0, "dat ro");
    rd(ADDR_ID, {4'h9, 6'h2A, 6'h05}, "id ro");
    rd(ADDR_TEL_A, 16'h007F, "telA kept");
    $display("t_ro done");
  endtask : t_ro
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    regAddr = '0;
    regWrite = 1'b0;
    regWdata = '0;
    telClipIn = 1'b0;
    tspxPinIn = 1'b1;
    tsmxPinIn = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_ctrl();
    t_pins();
    t_clip();
    t_adc();
    t_ro();
    results();
  end
endmodule : ctr_regs_test
`default_nettype wire
